// *** common/tlic_pkg.sv ***
package tlic_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses, low 16 bits)
    // -------------------------------------------------------------
    localparam logic [15:0] TLIC_ADDR_SYSCTL = 16'hfff2;
    localparam logic [15:0] TLIC_ADDR_SENSE = 16'hfff4;
    localparam logic [15:0] TLIC_ADDR_ENABLE = 16'hfff5;
    localparam logic [15:0] TLIC_ADDR_STATUS = 16'hfff6;
    localparam logic [15:0] TLIC_ADDR_PRIO_A = 16'hfff8;
    localparam logic [15:0] TLIC_ADDR_PRIO_B = 16'hfff9;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] TLIC_RST_SYSCTL = 8'h0b;
    localparam logic [7:0] TLIC_RST_ZERO = 8'h00;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int TLIC_SYS_ROLE_BIT = 3;
    localparam int TLIC_SYS_NMI_EDGE_BIT = 2;
    localparam int TLIC_PIN_COUNT = 6;
    localparam logic [7:0] TLIC_PIN_MASK = 8'h3f;
    // -------------------------------------------------------------
    // vector numbers
    // -------------------------------------------------------------
    localparam logic [5:0] TLIC_VEC_NMI = 6'h07;
    localparam logic [5:0] TLIC_VEC_PIN0 = 6'h0c;
    localparam logic [5:0] TLIC_VEC_INT_FIRST = 6'h14;
    localparam int TLIC_INT_COUNT = 41;
    localparam logic [5:0] TLIC_VEC_NONE = 6'h00;
    // -------------------------------------------------------------
    // priority bit select: index into {prio_b, prio_a}, 16 = none
    // -------------------------------------------------------------
    localparam logic [4:0] TLIC_PSEL_NONE = 5'h10;
endpackage

// *** logic/tlic_ctrl.sv ***
`timescale 1ns/1ns
// Overview of operation
// - every source but nonmaskable and vectors 22,23,48-51 (fixed at level 0) gets level 0 or 1 via two priority registers.
// - cpu interrupt mask and user mask bits give three masking levels.
// - each source presents its own vector number, no polling needed.
// - nonmaskable request wins always and ignores all masking.
// - each of six pins picks falling-edge or low-level sensing independently.
// - system control loads default on reset and hardware standby, keeps otherwise.
// - status flags accept only zero writes, which clear; ones do nothing.
// - system control bit 3 zero makes user flag a mask, one a user bit.
// - system control bit 2 picks nonmaskable edge: zero falling, one rising.
// - priority a bits 7 and 6 set pin 0 and pin 1 levels.
// - priority a bit 5 shares pins 2,3; bit 4 shares pins 4,5.
// - priority a bit 3 sets watchdog and refresh controller level.
// - priority a bits 2,1,0 set timer channels 0,1,2 levels.
// - priority b bits 7,6 set timer channels 3,4 levels.
// - priority b bit 5 sets both dma channel levels.
// - priority b bits 3,2 set serial channel 0 and 1 levels.
// - priority b bit 1 sets converter level.
// - priority b bits 4 and 0 are plain storage only.
// - both priority registers clear to zero on reset and hardware standby.
// - at equal level the smaller vector number wins.
// - flag sets while pin low in level mode, on falling edge in edge mode.
// - flag clears on zero write after read as one, or on its acceptance.
// - pin request reaches cpu only when its enable bit is one.
module tlic_ctrl
    import tlic_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic hw_standby_i,
    // register port
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pins
    input wire logic nmi_pin_i,
    input wire logic [5:0] external_request_pins_n_i,
    // peripheral requests, bit k is vector 20+k
    input wire logic [40:0] periph_req_i,
    // cpu side
    input wire logic ccr_int_mask_i,
    input wire logic user_mask_flag_i,
    input wire logic int_ack_i,
    input wire logic [5:0] int_ack_vector_i,
    output logic cpu_req_o,
    output logic [5:0] cpu_vector_o,
    output logic cpu_level_o,
    output logic user_flag_role_select_o
);
    import tlic_pkg::*;

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_n_reg;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // maps a vector number onto a bit of {prio_b, prio_a}
    function automatic logic [4:0] prio_sel(input logic [5:0] vec);
        logic [4:0] sel;
        sel = TLIC_PSEL_NONE;
        case (vec)
            6'h0c: sel = 5'h07;
            6'h0d: sel = 5'h06;
            6'h0e, 6'h0f: sel = 5'h05;
            6'h10, 6'h11: sel = 5'h04;
            6'h14, 6'h15: sel = 5'h03;
            6'h18, 6'h19, 6'h1a, 6'h1b: sel = 5'h02;
            6'h1c, 6'h1d, 6'h1e, 6'h1f: sel = 5'h01;
            6'h20, 6'h21, 6'h22, 6'h23: sel = 5'h00;
            6'h24, 6'h25, 6'h26, 6'h27: sel = 5'h0f;
            6'h28, 6'h29, 6'h2a, 6'h2b: sel = 5'h0e;
            6'h2c, 6'h2d, 6'h2e, 6'h2f: sel = 5'h0d;
            6'h34, 6'h35, 6'h36, 6'h37: sel = 5'h0b;
            6'h38, 6'h39, 6'h3a, 6'h3b: sel = 5'h0a;
            6'h3c: sel = 5'h09;
            default: sel = TLIC_PSEL_NONE;
        endcase
        return sel;
    endfunction

    // lowest set index of a 64-bit request map; zero means none
    function automatic logic [5:0] first_set(input logic [63:0] req);
        logic [5:0] idx;
        idx = TLIC_VEC_NONE;
        for (int k = 63; k >= 0; k--) begin
            if (req[k]) begin
                idx = 6'(k);
            end
        end
        return idx;
    endfunction

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [7:0] sysctl_reg;
    logic [7:0] sense_reg;
    logic [7:0] enable_reg;
    logic [5:0] flag_reg;
    logic [5:0] flag_seen_reg;
    logic [7:0] prio_a_reg;
    logic [7:0] prio_b_reg;
    logic nmi_prev_reg;
    logic nmi_pend_reg;
    logic [5:0] pin_prev_reg;
    logic [7:0] reg_rdata_reg;
    logic cpu_req_reg;
    logic [5:0] cpu_vector_reg;
    logic cpu_level_reg;

    // soft init: hardware standby reloads like a reset, software standby does not
    wire init_w = hw_standby_i;

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------
    wire hit_sys_w = (reg_addr_i == TLIC_ADDR_SYSCTL);
    wire hit_sense_w = (reg_addr_i == TLIC_ADDR_SENSE);
    wire hit_en_w = (reg_addr_i == TLIC_ADDR_ENABLE);
    wire hit_stat_w = (reg_addr_i == TLIC_ADDR_STATUS);
    wire hit_pa_w = (reg_addr_i == TLIC_ADDR_PRIO_A);
    wire hit_pb_w = (reg_addr_i == TLIC_ADDR_PRIO_B);

    wire [7:0] rdata_next = hit_sys_w ? sysctl_reg :
                            hit_sense_w ? sense_reg :
                            hit_en_w ? enable_reg :
                            hit_stat_w ? {2'b00, flag_reg} :
                            hit_pa_w ? prio_a_reg :
                            hit_pb_w ? prio_b_reg : TLIC_RST_ZERO;

    wire role_user_w = sysctl_reg[TLIC_SYS_ROLE_BIT];
    wire nmi_rise_w = sysctl_reg[TLIC_SYS_NMI_EDGE_BIT];

    // -------------------------------------------------------------
    // pin sensing and flags
    // -------------------------------------------------------------
    wire [5:0] pin_low_w = ~external_request_pins_n_i;
    wire [5:0] pin_fall_w = pin_prev_reg & ~external_request_pins_n_i;
    wire [5:0] sense_edge_w = sense_reg[5:0];
    wire [5:0] flag_set_w = (sense_edge_w & pin_fall_w) | (~sense_edge_w & pin_low_w);
    wire ack_pin_w = int_ack_i && (int_ack_vector_i >= TLIC_VEC_PIN0) &&
                     (int_ack_vector_i < TLIC_VEC_PIN0 + 6'd6);
    wire [5:0] ack_off_w = int_ack_vector_i - TLIC_VEC_PIN0;
    wire [5:0] ack_pin_hot_w = ack_pin_w ? (6'h01 << ack_off_w[2:0]) : 6'h00;
    // a zero written only clears a flag that software already saw as one
    wire [5:0] sw_clr_w = (reg_wr_i && hit_stat_w) ?
                          (~reg_wdata_i[5:0] & flag_seen_reg) : 6'h00;
    wire [5:0] flag_clr_w = sw_clr_w | ack_pin_hot_w;
    // set beats clear, so a level pin still low refires at once
    wire [5:0] flag_next = flag_set_w | (flag_reg & ~flag_clr_w);
    wire [5:0] seen_next = ((reg_rd_i && hit_stat_w) ? (flag_seen_reg | flag_reg) :
                           flag_seen_reg) & flag_next;

    // nonmaskable edge detector
    wire nmi_edge_w = nmi_rise_w ? (nmi_pin_i & ~nmi_prev_reg) :
                      (~nmi_pin_i & nmi_prev_reg);
    wire nmi_ack_w = int_ack_i && (int_ack_vector_i == TLIC_VEC_NMI);
    wire nmi_pend_next = nmi_edge_w | (nmi_pend_reg & ~nmi_ack_w);

    // -------------------------------------------------------------
    // request map by vector number and level split
    // -------------------------------------------------------------
    logic [63:0] req_map_w;
    logic [63:0] level1_map_w;
    wire [15:0] prio_bits_w = {prio_b_reg, prio_a_reg};
    always_comb begin
        req_map_w = 64'h0;
        req_map_w[TLIC_VEC_PIN0 +: TLIC_PIN_COUNT] = flag_reg & enable_reg[5:0];
        req_map_w[TLIC_VEC_INT_FIRST +: TLIC_INT_COUNT] = periph_req_i;
    end

    genvar gv;
    generate
        for (gv = 0; gv < 64; gv++) begin : g_lvl
            wire [4:0] sel_w = prio_sel(6'(gv));
            // bits 4 and 0 of priority b never appear in the map
            assign level1_map_w[gv] = (sel_w != TLIC_PSEL_NONE) &&
                                      prio_bits_w[sel_w[3:0]];
        end
    endgenerate

    // -------------------------------------------------------------
    // masking and arbitration
    // -------------------------------------------------------------
    // user role: mask bit blocks all; mask role: mask bit leaves level 1 unless ui set
    wire allow_l0_w = !ccr_int_mask_i;
    wire allow_l1_w = !ccr_int_mask_i ||
                      (!role_user_w && !user_mask_flag_i);
    wire [63:0] hi_req_w = req_map_w & level1_map_w & {64{allow_l1_w}};
    wire [63:0] lo_req_w = req_map_w & ~level1_map_w & {64{allow_l0_w}};
    wire [5:0] hi_vec_w = first_set(hi_req_w);
    wire [5:0] lo_vec_w = first_set(lo_req_w);
    wire hi_any_w = |hi_req_w;
    wire lo_any_w = |lo_req_w;

    wire req_next = nmi_pend_next || hi_any_w || lo_any_w;
    wire [5:0] vec_next = nmi_pend_next ? TLIC_VEC_NMI :
                          hi_any_w ? hi_vec_w :
                          lo_any_w ? lo_vec_w : TLIC_VEC_NONE;
    wire level_next = !nmi_pend_next && hi_any_w;

    // -------------------------------------------------------------
    // configuration registers, one short process each
    // -------------------------------------------------------------
    // standby reloads like a reset, so software must re-init after it
    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            sysctl_reg <= TLIC_RST_SYSCTL;
        end else if (init_w) begin
            sysctl_reg <= TLIC_RST_SYSCTL;
        end else if (reg_wr_i && hit_sys_w) begin
            sysctl_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            sense_reg <= TLIC_RST_ZERO;
        end else if (init_w) begin
            sense_reg <= TLIC_RST_ZERO;
        end else if (reg_wr_i && hit_sense_w) begin
            sense_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            enable_reg <= TLIC_RST_ZERO;
        end else if (init_w) begin
            enable_reg <= TLIC_RST_ZERO;
        end else if (reg_wr_i && hit_en_w) begin
            enable_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            prio_a_reg <= TLIC_RST_ZERO;
        end else if (init_w) begin
            prio_a_reg <= TLIC_RST_ZERO;
        end else if (reg_wr_i && hit_pa_w) begin
            prio_a_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            prio_b_reg <= TLIC_RST_ZERO;
        end else if (init_w) begin
            prio_b_reg <= TLIC_RST_ZERO;
        end else if (reg_wr_i && hit_pb_w) begin
            prio_b_reg <= reg_wdata_i;
        end
    end

    // -------------------------------------------------------------
    // flags and edge history
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            flag_reg <= 6'h00;
        end else if (init_w) begin
            flag_reg <= 6'h00;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            flag_seen_reg <= 6'h00;
        end else if (init_w) begin
            flag_seen_reg <= 6'h00;
        end else begin
            flag_seen_reg <= seen_next;
        end
    end

    // history follows the pins even in standby, so no false edge on leaving it
    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            pin_prev_reg <= 6'h3f;
        end else begin
            pin_prev_reg <= external_request_pins_n_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            nmi_prev_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_pin_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            nmi_pend_reg <= 1'b0;
        end else if (init_w) begin
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_pend_reg <= nmi_pend_next;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            reg_rdata_reg <= TLIC_RST_ZERO;
            cpu_req_reg <= 1'b0;
            cpu_vector_reg <= TLIC_VEC_NONE;
            cpu_level_reg <= 1'b0;
        end else begin
            reg_rdata_reg <= reg_rd_i ? rdata_next : TLIC_RST_ZERO;
            cpu_req_reg <= req_next && !init_w;
            cpu_vector_reg <= init_w ? TLIC_VEC_NONE : vec_next;
            cpu_level_reg <= level_next && !init_w;
        end
    end

    assign reg_rdata_o = reg_rdata_reg;
    assign cpu_req_o = cpu_req_reg;
    assign cpu_vector_o = cpu_vector_reg;
    assign cpu_level_o = cpu_level_reg;
    assign user_flag_role_select_o = sysctl_reg[TLIC_SYS_ROLE_BIT];
endmodule

// *** tb/tlic_ctrl_properties.sv ***
`timescale 1ns/1ns
module tlic_ctrl_properties
    import tlic_pkg::*;
(
    // watched ports
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic hw_standby_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic ccr_int_mask_i,
    input wire logic user_mask_flag_i,
    input wire logic cpu_req_o,
    input wire logic [5:0] cpu_vector_o,
    input wire logic cpu_level_o,
    input wire logic user_flag_role_select_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // standby re-init wins over a write in the same cycle
    wire sys_wr = reg_wr_i && reg_addr_i == TLIC_ADDR_SYSCTL && !hw_standby_i;
    wire sys_rd = reg_rd_i && reg_addr_i == TLIC_ADDR_SYSCTL && !hw_standby_i;
    // ---------------------------------------------
    // registers and masking
    // ---------------------------------------------
    role_clear_a: assert property (sys_wr && !reg_wdata_i[3] |=> !user_flag_role_select_o)
        else $error("role select not cleared by write");
    role_set_a: assert property (sys_wr && reg_wdata_i[3] |=> user_flag_role_select_o)
        else $error("role select not set by write");
    sysctl_read_a: assert property (sys_rd |=> reg_rdata_o[3] == user_flag_role_select_o)
        else $error("system control read disagrees with role select");
    status_rsvd_a: assert property (reg_rd_i && reg_addr_i == TLIC_ADDR_STATUS
        |=> reg_rdata_o[7:6] == 2'b00)
        else $error("status reserved bits not zero");
    standby_init_a: assert property (hw_standby_i |=> user_flag_role_select_o && !cpu_req_o)
        else $error("standby did not re-init");
    mask_all_a: assert property ($past(ccr_int_mask_i) && $past(user_flag_role_select_o)
        && cpu_req_o |-> cpu_vector_o == TLIC_VEC_NMI)
        else $error("maskable request shown while fully masked");
    ui_mask_a: assert property ($past(ccr_int_mask_i) && $past(user_mask_flag_i)
        && cpu_req_o |-> cpu_vector_o == TLIC_VEC_NMI)
        else $error("maskable request shown with both mask bits set");
    lvl1_only_a: assert property ($past(ccr_int_mask_i) && !$past(user_flag_role_select_o)
        && !$past(user_mask_flag_i) && cpu_req_o && cpu_vector_o != TLIC_VEC_NMI
        |-> cpu_level_o)
        else $error("level 0 request shown while level 0 masked");
    nmi_level_a: assert property (cpu_req_o && cpu_vector_o == TLIC_VEC_NMI |-> !cpu_level_o)
        else $error("nonmaskable request shown at level 1");
    cover property (cpu_req_o && cpu_level_o);
    cover property (cpu_req_o && cpu_vector_o == TLIC_VEC_NMI);
    cover property (hw_standby_i);
endmodule
bind tlic_ctrl tlic_ctrl_properties chk_u (.clk_sys_i, .reset_n_i, .hw_standby_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ccr_int_mask_i, .user_mask_flag_i,
    .cpu_req_o, .cpu_vector_o, .cpu_level_o, .user_flag_role_select_o);

// *** tb/tlic_cpu_model.sv ***
`timescale 1ns/1ns
module tlic_cpu_model (
    // clock and control
    input wire logic clk_sys_i,
    input wire logic take_i,
    input wire logic [1:0] lat_i,
    // controller side
    input wire logic req_i,
    input wire logic [5:0] vec_i,
    output logic ack_o = 1'b0,
    output logic [5:0] ack_vec_o = 6'h00,
    output int ack_cnt_o = 0
);
    logic [2:0] wait_q = 3'h0;
    logic done_q = 1'b0;
    // one accept per take window, after lat_i cycles of pending request
    always @(posedge clk_sys_i) begin
        ack_o <= 1'b0;
        // vector means nothing outside an accept, so keep it moving
        ack_vec_o <= ~ack_vec_o;
        if (!take_i) begin
            wait_q <= 3'h0;
            done_q <= 1'b0;
        end else if (req_i && !done_q) begin
            if (wait_q == {1'b0, lat_i}) begin
                ack_o <= 1'b1;
                ack_vec_o <= vec_i;
                ack_cnt_o <= ack_cnt_o + 1;
                done_q <= 1'b1;
            end
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule

// *** tb/test_two_level_interrupt_priority_ctrl.sv ***
`timescale 1ns/1ns
module test_two_level_interrupt_priority_ctrl;
    import tlic_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic stby = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic nmi = 1'b1;
    logic [5:0] pins_n = 6'h3f;
    logic [40:0] periph = '0;
    logic [40:0] all_src = '0;
    logic ccr_i = 1'b0;
    logic ui_i = 1'b0;
    logic take = 1'b0;
    logic [1:0] lat = 2'h0;
    logic rd_seen = 1'b0;
    logic ack, req, lvl, role;
    logic [5:0] ack_vec, vec;
    logic [7:0] rdata, d;
    logic [15:0] p;
    int ack_n;
    int fails = 0;
    int compares = 0;
    logic [7:0] exp_rd[$];
    logic [6:0] exp_ack[$];
    logic [15:0] adr[7] = '{16'hfff2, 16'hfff4, 16'hfff5, 16'hfff6, 16'hfff8, 16'hfff9, 16'hfff3};
    // winning vector per priority bit of {b, a}, 0 where the bit is plain storage
    logic [5:0] vt[16] = '{6'h20, 6'h1e, 6'h1a, 6'h15, 6'h10, 6'h0e, 6'h0d, 6'h0c,
        6'h00, 6'h3c, 6'h38, 6'h34, 6'h00, 6'h2c, 6'h2a, 6'h24};
    always #25 clk_sys_i = ~clk_sys_i;
    tlic_ctrl dut_u (.clk_sys_i, .reset_n_i, .hw_standby_i(stby), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .nmi_pin_i(nmi), .external_request_pins_n_i(pins_n), .periph_req_i(periph),
        .ccr_int_mask_i(ccr_i), .user_mask_flag_i(ui_i), .int_ack_i(ack),
        .int_ack_vector_i(ack_vec), .cpu_req_o(req), .cpu_vector_o(vec),
        .cpu_level_o(lvl), .user_flag_role_select_o(role));
    tlic_cpu_model cpu_u (.clk_sys_i, .take_i(take), .lat_i(lat), .req_i(req), .vec_i(vec),
        .ack_o(ack), .ack_vec_o(ack_vec), .ack_cnt_o(ack_n));
    // ---------------------------------------------
    // checking
    // ---------------------------------------------
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge clk_sys_i) rd_seen <= rd_s;
    always @(negedge clk_sys_i) begin
        if (rd_seen) check("rdata", exp_rd.size() ? exp_rd.pop_front() : 8'hxx, rdata);
        if (ack) check("vector", exp_ack.size() ? {1'b0, exp_ack.pop_front()} : 8'hxx,
            {1'b0, lvl, ack_vec});
    end
    task automatic print_verdict;
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ---------------------------------------------
    // drivers
    // ---------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk_sys_i);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge clk_sys_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys_i);
        rd_s <= 1'b0;
    endtask
    task automatic pulse(input int n);
        @(posedge clk_sys_i);
        pins_n[n] <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        pins_n[n] <= 1'b1;
    endtask
    task automatic accept(input logic [6:0] e);
        int n;
        n = ack_n;
        exp_ack.push_back(e);
        @(posedge clk_sys_i);
        lat <= 2'($urandom);
        take <= 1'b1;
        for (int i = 0; i < 40 && ack_n == n; i++) @(posedge clk_sys_i);
        take <= 1'b0;
        if (ack_n == n) begin
            fails++;
            $display("MISMATCH accept expected %h seen none", e);
        end
    endtask
    function automatic logic [6:0] best(input logic [15:0] v);
        logic [6:0] r;
        r = {1'b0, TLIC_VEC_PIN0};
        for (int i = 0; i < 16; i++)
            if (v[i] && vt[i] != 6'h00 && (!r[6] || vt[i] < r[5:0])) r = {1'b1, vt[i]};
        return r;
    endfunction
    initial begin
        #(50 * 20000);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'ha8b3));
        foreach (vt[i]) if (vt[i] >= 6'h14) all_src[vt[i] - 6'h14] = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        foreach (adr[i]) rd(adr[i], i == 0 ? TLIC_RST_SYSCTL : TLIC_RST_ZERO);
        foreach (adr[i]) begin
            d = 8'($urandom);
            wr(adr[i], d);
            rd(adr[i], (i == 3 || i == 6) ? 8'h00 : d);
        end
        wr(TLIC_ADDR_SYSCTL, TLIC_RST_SYSCTL);
        wr(TLIC_ADDR_SENSE, 8'h3f);
        wr(TLIC_ADDR_ENABLE, 8'h00);
        wr(TLIC_ADDR_PRIO_A, TLIC_RST_ZERO);
        wr(TLIC_ADDR_PRIO_B, TLIC_RST_ZERO);
        pulse(3);
        rd(TLIC_ADDR_STATUS, 8'h08);
        @(negedge clk_sys_i);
        check("request", 8'h00, {7'h00, req});
        wr(TLIC_ADDR_STATUS, 8'h00);
        rd(TLIC_ADDR_STATUS, 8'h00);
        wr(TLIC_ADDR_ENABLE, 8'h08);
        pulse(3);
        accept({1'b0, 6'h0f});
        rd(TLIC_ADDR_STATUS, 8'h00);
        ccr_i <= 1'b1;
        periph[1] <= 1'b1;
        wr(TLIC_ADDR_PRIO_A, 8'h08);
        nmi <= 1'b0;
        accept({1'b0, TLIC_VEC_NMI});
        wr(TLIC_ADDR_SYSCTL, 8'h07);
        accept({1'b1, 6'h15});
        check("role", 8'h00, {7'h00, role});
        ui_i <= 1'b1;
        nmi <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        accept({1'b0, TLIC_VEC_NMI});
        ccr_i <= 1'b0;
        ui_i <= 1'b0;
        periph <= all_src;
        pins_n <= 6'h00;
        wr(TLIC_ADDR_SYSCTL, TLIC_RST_SYSCTL);
        wr(TLIC_ADDR_SENSE, 8'h00);
        wr(TLIC_ADDR_ENABLE, 8'h3f);
        for (int i = 0; i < 33; i++) begin
            p = i < 16 ? 16'h0001 << i : (i == 16 ? 16'h0000 : 16'($urandom));
            wr(TLIC_ADDR_PRIO_A, p[7:0]);
            wr(TLIC_ADDR_PRIO_B, p[15:8]);
            repeat (3) @(posedge clk_sys_i);
            accept(best(p));
        end
        @(posedge clk_sys_i);
        stby <= 1'b1;
        @(posedge clk_sys_i);
        stby <= 1'b0;
        rd(TLIC_ADDR_SYSCTL, TLIC_RST_SYSCTL);
        rd(TLIC_ADDR_PRIO_B, TLIC_RST_ZERO);
        check("role", 8'h01, {7'h00, role});
        repeat (3) @(posedge clk_sys_i);
        print_verdict();
    end
endmodule
